// File: tb/test_trim_and_swap_delay_regs.sv
`timescale 1ns/10ps
`include "trim_regs_params.svh"

// ---------------------------------------------------------------
// random register traffic, refusals and timed core swaps
// ---------------------------------------------------------------
module test_trim_and_swap_delay_regs;
   logic        i_clk, i_reset, i_psel, i_penable, i_pwrite, e;
   logic        i_cal_enable, i_swap_request, o_pready, o_pslverr, o_cores_overlap, o_swap_done;
   logic [13:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, i_fuse_term, o_term_adjust, q;
   logic [7:0]  i_fuse_gain, o_gain_adjust, d;
   logic [3:0]  i_fuse_bandgap, o_bandgap_adjust;
   logic [4:0]  o_swap_overlap_delay;
   logic [7:0]  exp_val[7];
   int          error_cnt, checks, len, k;
   logic [11:0] idx[7] = '{`IDX_GAIN_ADJUST, `IDX_BANDGAP_ADJUST, `IDX_TERM_ADJUST_A,
      `IDX_TERM_ADJUST_B, `IDX_TERM_ADJUST_C, `IDX_TERM_ADJUST_D, `IDX_SWAP_OVERLAP};
   logic [7:0]  msk[7] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};
   logic [4:0]  dly[3] = '{5'h1f, 5'h00, 5'h07};

   trim_and_swap_delay_regs DUT (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_fuse_gain, .i_fuse_bandgap, .i_fuse_term,
      .i_cal_enable, .i_swap_request, .o_gain_adjust, .o_bandgap_adjust, .o_term_adjust,
      .o_swap_overlap_delay, .o_cores_overlap, .o_swap_done);

   initial begin
      i_clk = 1'h0;
      forever #12.5 i_clk = ~i_clk;
   end

   function automatic logic [31:0] ovl_len(input logic [4:0] v);
      return 32'h4 + {26'h0, v, 1'h0};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one transfer, then an idle cycle so no strobe is driven twice at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [1:0] lo,
                      input logic [31:0] wd);
      int n;
      n = 0;
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= {a, lo};
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'h1 && n < 50);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      if (n >= 50) chk(32'h0, 32'h1);
      @(posedge i_clk);
   endtask

   task automatic rd_all;
      for (int i = 0; i < 7; i++) begin
         apb(1'h0, idx[i], 2'h0, 32'h0);
         chk(q, {24'h0, exp_val[i]});
         chk({31'h0, e}, 32'h0);
      end
   endtask

   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      end_sim;
   end

   initial begin
      void'($urandom(91));
      {i_psel, i_penable, i_pwrite, i_cal_enable, i_swap_request} = 5'h0;
      i_paddr = 14'h0;
      i_pwdata = 32'h0;
      i_fuse_gain = 8'($urandom);
      i_fuse_bandgap = 4'($urandom);
      i_fuse_term = $urandom;
      i_reset = 1'h1;
      repeat (20) @(posedge i_clk);
      chk({27'h0, o_swap_overlap_delay}, 32'h8);
      i_reset <= 1'h0;
      repeat (2) @(posedge i_clk);
      exp_val = '{i_fuse_gain, {4'h0, i_fuse_bandgap}, i_fuse_term[7:0], i_fuse_term[15:8],
         i_fuse_term[23:16], i_fuse_term[31:24], 8'h08};
      rd_all;
      // reserved bits always written as zero; swap control never used for range
      for (int j = 0; j < 30; j++) begin
         k = $urandom_range(6);
         d = 8'($urandom) & msk[k];
         apb(1'h1, idx[k], 2'h0, {24'h0, d});
         exp_val[k] = d;
      end
      rd_all;
      chk({24'h0, o_gain_adjust}, {24'h0, exp_val[0]});
      chk({28'h0, o_bandgap_adjust}, {24'h0, exp_val[1]});
      chk(o_term_adjust, {exp_val[5], exp_val[4], exp_val[3], exp_val[2]});
      apb(1'h0, 12'h07b, 2'h0, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'h1, `IDX_GAIN_ADJUST, 2'h2, {24'h0, ~exp_val[0]});
      chk({31'h0, e}, 32'h1);
      apb(1'h0, `IDX_GAIN_ADJUST, 2'h0, 32'h0);
      chk(q, {24'h0, exp_val[0]});
      apb(1'h1, `IDX_SWAP_CTRL, 2'h0, 32'h1);
      // overlap changed only with calibration off
      foreach (dly[m]) begin
         i_cal_enable <= 1'h0;
         apb(1'h1, `IDX_SWAP_OVERLAP, 2'h0, {27'h0, dly[m]});
         apb(1'h0, `IDX_SWAP_OVERLAP, 2'h0, 32'h0);
         chk(q, {27'h0, dly[m]});
         i_cal_enable <= 1'h1;
         i_swap_request <= 1'h1;
         @(posedge i_clk);
         i_swap_request <= 1'h0;
         len = 0;
         while (o_cores_overlap !== 1'h1 && len < 20) begin
            @(posedge i_clk);
            len++;
         end
         len = 0;
         while (o_cores_overlap === 1'h1 && len < 100) begin
            @(posedge i_clk);
            len++;
         end
         chk(len, ovl_len(dly[m]));
         chk({31'h0, o_swap_done}, 32'h1);
         repeat (4) @(posedge i_clk);
      end
      apb(1'h0, `IDX_SWAP_STATUS, 2'h0, 32'h0);
      chk({22'h0, q[9:0]}, 32'h103);
      end_sim;
   end
endmodule // test_trim_and_swap_delay_regs

// File: tb/trim_and_swap_delay_regs_assertions.sv
`timescale 1ns/10ps
`include "trim_regs_params.svh"

// ---------------------------------------------------------------
// bus timing, write landing and swap overlap checks
// ---------------------------------------------------------------
module trim_regs_checker (
   // clock, reset and bus
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [13:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // trims and swap status
   input wire logic [7:0]  i_fuse_gain,
   input wire logic [7:0]  o_gain_adjust,
   input wire logic [3:0]  o_bandgap_adjust,
   input wire logic [4:0]  o_swap_overlap_delay,
   input wire logic        o_cores_overlap,
   input wire logic        o_swap_done
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic [6:0] ovl_cnt_r;
   wire        wr_ok = i_psel & i_penable & i_pwrite & o_pready & ~o_pslverr;
   // overlap length counter; clears whenever the cores stop sharing
   always_ff @(posedge i_clk) ovl_cnt_r <= o_cores_overlap ? ovl_cnt_r + 7'h01 : 7'h00;
   // trims show up two edges after the accepted access
   a_pready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
   a_pready_one_cycle: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   a_unaligned_err: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
      else $error("unaligned access not refused");
   a_gain_write: assert property (wr_ok && i_paddr == {`IDX_GAIN_ADJUST, 2'h0}
      |-> ##2 o_gain_adjust == $past(i_pwdata[7:0], 2)) else $error("gain write lost");
   a_bandgap_write: assert property (wr_ok && i_paddr == {`IDX_BANDGAP_ADJUST, 2'h0}
      |-> ##2 o_bandgap_adjust == $past(i_pwdata[3:0], 2)) else $error("bandgap write lost");
   a_overlap_write: assert property (wr_ok && i_paddr == {`IDX_SWAP_OVERLAP, 2'h0}
      |-> ##2 o_swap_overlap_delay == $past(i_pwdata[4:0], 2)) else $error("overlap write lost");
   a_fuse_gain_load: assert property ($fell(i_reset)
      |-> ##2 o_gain_adjust == $past(i_fuse_gain, 2)) else $error("gain fuse not loaded");
   a_overlap_length: assert property ($fell(o_cores_overlap)
      |-> ovl_cnt_r == 7'h04 + {1'h0, o_swap_overlap_delay, 1'h0}) else $error("overlap length");
   a_done_follows: assert property ($fell(o_cores_overlap) |-> ##[0:1] o_swap_done)
      else $error("no done after overlap");
   a_done_pulse: assert property (o_swap_done |=> !o_swap_done)
      else $error("done not a pulse");
   c_write: cover property (wr_ok);
   c_refused: cover property (o_pready && o_pslverr);
   c_swap: cover property ($fell(o_cores_overlap));
endmodule // trim_regs_checker

bind trim_and_swap_delay_regs trim_regs_checker u_chk (.i_clk, .i_reset, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_fuse_gain, .o_gain_adjust,
   .o_bandgap_adjust, .o_swap_overlap_delay, .o_cores_overlap, .o_swap_done);

// File: verilog/swap_overlap_timer.sv
`timescale 1ns/10ps
`include "trim_regs_params.svh"

// ---------------------------------------------------------------
// overlap timer: both cores share the input for 4 + 2*delay cycles
// ---------------------------------------------------------------
module swap_overlap_timer (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // control
   input  wire logic       i_start,
   input  wire logic [4:0] i_delay,
   // status
   output logic            o_overlap,
   output logic            o_done
);
   trim_regs_pkg::swap_state_t state_r;
   logic [6:0]                 count_r;
   wire  [6:0]                 span = `OVERLAP_BASE + {1'b0, i_delay, 1'b0};

   // count down the shared-sampling window, then pulse done
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_r   <= trim_regs_pkg::SWAP_IDLE;
         count_r   <= 7'h00;
         o_overlap <= 1'b0;
         o_done    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state_r)
            trim_regs_pkg::SWAP_IDLE: begin
               if (i_start) begin
                  state_r   <= trim_regs_pkg::SWAP_OVERLAP;
                  count_r   <= span - 7'h01;
                  o_overlap <= 1'b1;
               end
            end
            trim_regs_pkg::SWAP_OVERLAP: begin
               if (count_r == 7'h00) begin
                  state_r   <= trim_regs_pkg::SWAP_DONE;
                  o_overlap <= 1'b0;
                  o_done    <= 1'b1;
               end else begin
                  count_r <= count_r - 7'h01;
               end
            end
            default: begin
               state_r <= trim_regs_pkg::SWAP_IDLE;
            end
         endcase
      end
   end
endmodule // swap_overlap_timer

// File: verilog/trim_and_swap_delay_regs.sv
// Contract
// - eight-bit gain trim, one adjustment for all converter cores.
// - four-bit reference trim in low nibble of its byte.
// - trim registers preset from fuse values, not constants.
// - fuse-loaded reference trim readable after reset and writable.
// - four eight-bit termination trims, one per input pair.
// - cores share the input for 4 + 2*delay core-clock cycles.
// - overlap field bits 4:0, range 0..31, resets to 8.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "trim_regs_params.svh"

module trim_and_swap_delay_regs (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [13:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // factory fuse contents, stable from reset
   input  wire logic [7:0]  i_fuse_gain,
   input  wire logic [3:0]  i_fuse_bandgap,
   input  wire logic [31:0] i_fuse_term,
   // calibration
   input  wire logic        i_cal_enable,
   input  wire logic        i_swap_request,
   // trims and swap status to the analog side
   output logic [7:0]       o_gain_adjust,
   output logic [3:0]       o_bandgap_adjust,
   output logic [31:0]      o_term_adjust,
   output logic [4:0]       o_swap_overlap_delay,
   output logic             o_cores_overlap,
   output logic             o_swap_done
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [13:0] addr, input logic [11:0] idx);
      hit = (addr[13:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   logic [7:0] gain_r;
   logic [3:0] bandgap_r;
   logic [7:0] term_r [4];
   logic [4:0] overlap_r;
   logic       fuse_load_r;
   logic       swaps_r;
   logic [7:0] swap_count_r;
   logic       timer_overlap;
   logic       timer_done;

   wire access  = i_psel & i_penable;
   wire wr      = access & i_pwrite;
   wire hit_g   = hit(i_paddr, `IDX_GAIN_ADJUST);
   wire hit_bg  = hit(i_paddr, `IDX_BANDGAP_ADJUST);
   wire hit_ov  = hit(i_paddr, `IDX_SWAP_OVERLAP);
   wire hit_ct  = hit(i_paddr, `IDX_SWAP_CTRL);
   wire hit_st  = hit(i_paddr, `IDX_SWAP_STATUS);
   wire [3:0] hit_t;
   wire       hit_any;
   logic [31:0] rdata;

   // one decode per termination register
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_term_hit
         assign hit_t[gi] = hit(i_paddr, `IDX_TERM_ADJUST_A + 12'(gi));
      end
   endgenerate

   assign hit_any = hit_g | hit_bg | hit_ov | hit_ct | hit_st | (|hit_t);

   // read mux; unmapped addresses read zero and flag an error
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_g) begin
         rdata[7:0] = gain_r;
      end else if (hit_bg) begin
         rdata[`BANDGAP_MSB:0] = bandgap_r;
      end else if (hit_t[0]) begin
         rdata[7:0] = term_r[0];
      end else if (hit_t[1]) begin
         rdata[7:0] = term_r[1];
      end else if (hit_t[2]) begin
         rdata[7:0] = term_r[2];
      end else if (hit_t[3]) begin
         rdata[7:0] = term_r[3];
      end else if (hit_ov) begin
         rdata[`OVERLAP_MSB:0] = overlap_r;
      end else if (hit_ct) begin
         rdata[0] = swaps_r;
      end else if (hit_st) begin
         rdata[9:0] = {timer_overlap, i_cal_enable, swap_count_r};
      end
   end

   // ---------------------------------------------------------------
   // apb response: zero wait states, registered answer
   // ---------------------------------------------------------------
   // a setup cycle is answered in the very next cycle, so the master
   // never waits more than one access cycle; the answer is built from
   // the setup-phase address, which the master holds through access
   wire        setup_phase = i_psel & ~i_penable;
   wire        pready_nxt  = setup_phase;
   wire        pslverr_nxt = setup_phase & ~hit_any;
   wire [31:0] prdata_nxt  = (setup_phase & ~i_pwrite) ? rdata : 32'h0000_0000;

   // ready stands for exactly the access cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= pready_nxt;
      end
   end

   // refusal of unmapped or unaligned addresses; writes there are dropped
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= pslverr_nxt;
      end
   end

   // read data captured at setup, steady through the access cycle;
   // writes and idle cycles return zero so the bus never shows stale data
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_prdata <= 32'h0000_0000;
      end else begin
         o_prdata <= prdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // trim registers; fuses are copied one cycle after reset release
   // because an async copy of a port would defeat reset integrity
   // ---------------------------------------------------------------
   // a write lands only at the access edge where ready is sampled high;
   // unmapped or unaligned addresses raise no hit, so nothing is stored
   wire       take    = wr & o_pready;
   wire       we_gain = take & hit_g;
   wire       we_bg   = take & hit_bg;
   wire       we_ov   = take & hit_ov;
   wire       we_ct   = take & hit_ct;
   wire [3:0] we_term = {4{take}} & hit_t;

   // write data fields; reserved bits are not stored and read back zero
   wire [7:0]            wd_byte    = i_pwdata[7:0];
   wire [`BANDGAP_MSB:0] wd_bandgap = i_pwdata[`BANDGAP_MSB:0];
   wire [`OVERLAP_MSB:0] wd_overlap = i_pwdata[`OVERLAP_MSB:0];

   // one-shot fuse copy in the first cycle out of reset; a bus write in
   // that same cycle loses to the fuse value, so software starts later
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         fuse_load_r <= 1'b1;
      end else begin
         fuse_load_r <= 1'b0;
      end
   end

   // gain trim: one value shared by every converter core
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         gain_r <= 8'h00;
      end else if (fuse_load_r) begin
         gain_r <= i_fuse_gain;
      end else if (we_gain) begin
         gain_r <= wd_byte;
      end
   end

   // reference trim: only the low nibble is stored
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         bandgap_r <= 4'h0;
      end else if (fuse_load_r) begin
         bandgap_r <= i_fuse_bandgap;
      end else if (we_bg) begin
         bandgap_r <= wd_bandgap;
      end
   end

   // overlap delay resets to a fixed value, not from fuses; a write
   // while calibration runs is software's fault and is stored anyway,
   // so a window already open keeps the length it started with
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         overlap_r <= `OVERLAP_RESET;
      end else if (we_ov) begin
         overlap_r <= wd_overlap;
      end
   end

   // swap enable bit of the control register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         swaps_r <= 1'b0;
      end else if (we_ct) begin
         swaps_r <= i_pwdata[0];
      end
   end

   // termination trims, one per input pair; each element has its own
   // process so the decode of one pair never disturbs another
   generate
      for (gi = 0; gi < 4; gi++) begin : g_term
         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               term_r[gi] <= 8'h00;
            end else if (fuse_load_r) begin
               term_r[gi] <= i_fuse_term[gi*8 +: 8];
            end else if (we_term[gi]) begin
               term_r[gi] <= wd_byte;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // swap overlap window
   // ---------------------------------------------------------------
   // a request is taken only with calibration on, swaps enabled and no
   // window open; requests inside a window are dropped, not queued
   wire swap_start = i_cal_enable & swaps_r & i_swap_request & ~timer_overlap;

   swap_overlap_timer u_timer (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_start   (swap_start),
      .i_delay   (overlap_r),
      .o_overlap (timer_overlap),
      .o_done    (timer_done)
   );

   // completed swaps; the count saturates at 255 so a long run never
   // wraps back to zero and hides that swaps took place
   wire       count_full     = (swap_count_r == 8'hff);
   wire [7:0] swap_count_nxt = swap_count_r + 8'h01;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         swap_count_r <= 8'h00;
      end else if (timer_done && !count_full) begin
         swap_count_r <= swap_count_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all from flops and one cycle behind the registers
   // ---------------------------------------------------------------
   // the extra stage keeps the analog trims free of decode glitches,
   // traded for one cycle of latency after each write
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_gain_adjust    <= 8'h00;
         o_bandgap_adjust <= 4'h0;
      end else begin
         o_gain_adjust    <= gain_r;
         o_bandgap_adjust <= bandgap_r;
      end
   end

   // termination trims packed with pair a in the low byte, d on top
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_term_adjust <= 32'h0000_0000;
      end else begin
         o_term_adjust <= {term_r[3], term_r[2], term_r[1], term_r[0]};
      end
   end

   // overlap delay copy for the swap logic of the converter cores
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_swap_overlap_delay <= `OVERLAP_RESET;
      end else begin
         o_swap_overlap_delay <= overlap_r;
      end
   end

   // swap status: window one cycle behind the timer, done a pulse
   // in the cycle right after the window closes
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_cores_overlap <= 1'b0;
         o_swap_done     <= 1'b0;
      end else begin
         o_cores_overlap <= timer_overlap;
         o_swap_done     <= timer_done;
      end
   end
endmodule // trim_and_swap_delay_regs

// File: verilog/trim_regs_params.svh
`ifndef TRIM_REGS_PARAMS_SVH
`define TRIM_REGS_PARAMS_SVH

// ---------------------------------------------------------------
// register indices (printed offsets); byte address is index * 4
// ---------------------------------------------------------------
`define IDX_GAIN_ADJUST       12'h07a
`define IDX_BANDGAP_ADJUST    12'h07c
`define IDX_TERM_ADJUST_A     12'h07e
`define IDX_TERM_ADJUST_B     12'h07f
`define IDX_TERM_ADJUST_C     12'h080
`define IDX_TERM_ADJUST_D     12'h081
`define IDX_SWAP_OVERLAP      12'h09a
`define IDX_SWAP_CTRL         12'h0a0
`define IDX_SWAP_STATUS       12'h0a1

// ---------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------
`define BANDGAP_MSB           3
`define OVERLAP_MSB           4
`define OVERLAP_RESET         5'h08
`define OVERLAP_BASE          7'h04
`define SWAP_CTRL_RESET       8'h00

`endif

// File: verilog/trim_regs_pkg.sv
package trim_regs_pkg;
   // swap sequencer states
   typedef enum logic [1:0] {
      SWAP_IDLE,
      SWAP_OVERLAP,
      SWAP_DONE
   } swap_state_t;
endpackage
